/* tldp_pkg.sv */
// Package: constants, register map and carrier types of the lane debug port block
package tldp_pkg;

   localparam int unsigned LANE_COUNT = 2;

   // Loopback codes
   localparam logic [2:0] LB_NONE      = 3'h0;
   localparam logic [2:0] LB_NEAR_PCS  = 3'h1;
   localparam logic [2:0] LB_NEAR_PMA  = 3'h2;
   localparam logic [2:0] LB_FAR_PMA   = 3'h4;
   localparam logic [2:0] LB_FAR_PCS   = 3'h6;

   // Register byte offsets (APB, one word each)
   localparam logic [11:0] REG_LOOPBACK   = 12'h41c;
   localparam logic [11:0] REG_TXSWING    = 12'h508;
   localparam logic [11:0] REG_TXPOL      = 12'h510;
   localparam logic [11:0] REG_RXPOL      = 12'h604;
   localparam logic [11:0] REG_RXLPMEN    = 12'h608;
   localparam logic [11:0] REG_RXEQRST    = 12'h60c;
   localparam logic [11:0] REG_TXPRE      = 12'h418;
   localparam logic [11:0] REG_TXPOST     = 12'h414;
   localparam logic [11:0] REG_RXPD       = 12'h404;
   localparam logic [11:0] REG_TXPD       = 12'h504;
   localparam logic [11:0] REG_MGMT_EN    = 12'h700;
   localparam logic [11:0] REG_LANE_STAT  = 12'h704;

   // Reset values
   localparam logic [31:0] RST_ZERO = 32'h0;

   // Lane status word bit positions
   localparam int unsigned ST_PLL  = 0;
   localparam int unsigned ST_RXD  = 1;
   localparam int unsigned ST_PMAD = 2;
   localparam int unsigned ST_ESE  = 3;
   localparam int unsigned ST_PRBS = 4;
   localparam int unsigned ST_COMMA = 5;
   localparam int unsigned ST_STRIDE = 8;

   // Per-lane control bundle toward a transceiver lane
   typedef struct packed {
      logic [2:0] loopback;
      logic       rx_invert;
      logic       tx_invert;
      logic       eq_reset;
      logic       lpm_select;
      logic [4:0] pre;
      logic [4:0] post;
      logic [3:0] swing;
      logic [1:0] rx_pd;
      logic [1:0] tx_pd;
   } tldp_ctrl_s;

   // Per-lane status bundle from a transceiver lane
   typedef struct packed {
      logic       pll_locked;
      logic       rx_done;
      logic       pma_done;
      logic       eye_err;
      logic       prbs_err;
      logic       comma;
   } tldp_stat_s;

endpackage

/* tldp_lane_debug.sv */
// Top module: per-lane transceiver debug port bundle with APB management option
//
// Notes on behaviour
// - Analog reset-done output is asynchronous passthrough
// - Receive reset-done reported in receive clock domain
// - Buffer status: three bits rx, two tx
// - PLL lock output high when locked
// - Eye-scan trigger high causes trigger event
// - Eye-scan error output follows lane error
// - Loopback codes 000, 001, 010 decoded
// - Loopback codes 100 far PMA, 110 far PCS
// - Management mode replaces the loopback through power-down ports with registers
// - Receive invert flips incoming serial data
// - Transmit invert flips outgoing serial data
// - Equaliser reset resets both equaliser datapaths
// - Select 1 picks low-power equaliser path
// - Force-error injects errors into pattern transmitter
// - Pattern error flag; separate counter clear input
// - Recovery hold freezes the recovery loop
// - Per-byte disparity and invalid-code error flags
// - Comma seen high on valid comma
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps

module tldp_lane_debug (
   input  wire logic                               pclk,
   input  wire logic                               presetn,
   // APB slave
   input  wire logic                               psel,
   input  wire logic                               penable,
   input  wire logic                               pwrite,
   input  wire logic [11:0]                        paddr,
   input  wire logic [31:0]                        pwdata,
   output logic      [31:0]                        prdata,
   output logic                                    pready,
   output logic                                    pslverr,
   // User-side debug ports (loopback through power-down selects used only when management mode is off; the rest always)
   input  wire logic [tldp_pkg::LANE_COUNT-1:0]    rx_coding_sublayer_reset,
   input  wire logic [tldp_pkg::LANE_COUNT-1:0]    rx_elastic_buffer_reset,
   input  wire logic [tldp_pkg::LANE_COUNT*3-1:0]  rx_line_rate_select,
   input  wire logic [tldp_pkg::LANE_COUNT-1:0]    eye_scan_trigger,
   input  wire logic [tldp_pkg::LANE_COUNT-1:0]    eye_scan_reset,
   input  wire logic [tldp_pkg::LANE_COUNT*3-1:0]  lane_loopback_select,
   input  wire logic [tldp_pkg::LANE_COUNT-1:0]    rx_invert_data,
   input  wire logic [tldp_pkg::LANE_COUNT-1:0]    tx_invert_data,
   input  wire logic [tldp_pkg::LANE_COUNT-1:0]    rx_equaliser_reset,
   input  wire logic [tldp_pkg::LANE_COUNT-1:0]    rx_low_power_equaliser_select,
   input  wire logic [tldp_pkg::LANE_COUNT*5-1:0]  tx_pre_emphasis_pre,
   input  wire logic [tldp_pkg::LANE_COUNT*5-1:0]  tx_pre_emphasis_post,
   input  wire logic [tldp_pkg::LANE_COUNT*4-1:0]  tx_driver_swing,
   input  wire logic [tldp_pkg::LANE_COUNT*2-1:0]  rx_power_down_select,
   input  wire logic [tldp_pkg::LANE_COUNT*2-1:0]  tx_power_down_select,
   input  wire logic [tldp_pkg::LANE_COUNT-1:0]    tx_pattern_force_error,
   input  wire logic [tldp_pkg::LANE_COUNT-1:0]    tx_output_inhibit,
   input  wire logic [tldp_pkg::LANE_COUNT*4-1:0]  rx_pattern_checker_select,
   input  wire logic [tldp_pkg::LANE_COUNT-1:0]    rx_pattern_error_count_clear,
   input  wire logic [tldp_pkg::LANE_COUNT-1:0]    rx_recovery_loop_hold,
   // User-side status
   output logic      [tldp_pkg::LANE_COUNT-1:0]    rx_analog_reset_done,
   output logic      [tldp_pkg::LANE_COUNT-1:0]    rx_reset_complete,
   output logic      [tldp_pkg::LANE_COUNT*2-1:0]  tx_elastic_buffer_state,
   output logic      [tldp_pkg::LANE_COUNT*3-1:0]  rx_elastic_buffer_state,
   output logic      [tldp_pkg::LANE_COUNT-1:0]    channel_pll_locked,
   output logic      [tldp_pkg::LANE_COUNT-1:0]    eye_scan_error,
   output logic      [tldp_pkg::LANE_COUNT-1:0]    rx_pattern_error,
   output logic      [tldp_pkg::LANE_COUNT*4-1:0]  rx_disparity_error,
   output logic      [tldp_pkg::LANE_COUNT*4-1:0]  rx_invalid_code_error,
   output logic      [tldp_pkg::LANE_COUNT-1:0]    rx_comma_seen,
   // Lane side: controls to the hard lane_count
   output tldp_pkg::tldp_ctrl_s [tldp_pkg::LANE_COUNT-1:0] lane_ctrl,
   output logic      [tldp_pkg::LANE_COUNT-1:0]    lane_pcs_reset,
   output logic      [tldp_pkg::LANE_COUNT-1:0]    lane_buf_reset,
   output logic      [tldp_pkg::LANE_COUNT*3-1:0]  lane_rate,
   output logic      [tldp_pkg::LANE_COUNT-1:0]    lane_eye_trigger,
   output logic      [tldp_pkg::LANE_COUNT-1:0]    lane_eye_reset,
   output logic      [tldp_pkg::LANE_COUNT-1:0]    lane_force_error,
   output logic      [tldp_pkg::LANE_COUNT-1:0]    lane_tx_inhibit,
   output logic      [tldp_pkg::LANE_COUNT*4-1:0]  lane_prbs_select,
   output logic      [tldp_pkg::LANE_COUNT-1:0]    lane_prbs_count_clear,
   output logic      [tldp_pkg::LANE_COUNT-1:0]    lane_cdr_hold,
   output logic      [tldp_pkg::LANE_COUNT-1:0]    lane_near_pcs_loop,
   output logic      [tldp_pkg::LANE_COUNT-1:0]    lane_near_pma_loop,
   output logic      [tldp_pkg::LANE_COUNT-1:0]    lane_far_pma_loop,
   output logic      [tldp_pkg::LANE_COUNT-1:0]    lane_far_pcs_loop,
   // Lane side: status from the hard lane_count
   input  tldp_pkg::tldp_stat_s [tldp_pkg::LANE_COUNT-1:0] lane_stat,
   input  wire logic [tldp_pkg::LANE_COUNT*2-1:0]  lane_tx_buf_state,
   input  wire logic [tldp_pkg::LANE_COUNT*3-1:0]  lane_rx_buf_state,
   input  wire logic [tldp_pkg::LANE_COUNT*4-1:0]  lane_disp_err,
   input  wire logic [tldp_pkg::LANE_COUNT*4-1:0]  lane_code_err
);

   localparam int unsigned L = tldp_pkg::LANE_COUNT;

   // ------------------------------------------------------------
   // Management registers
   // ------------------------------------------------------------
   logic            mgmt_en_q;
   logic [L*3-1:0]  loopback_q;
   logic [L-1:0]    rx_pol_q;
   logic [L-1:0]    tx_pol_q;
   logic [L-1:0]    lpm_q;
   logic [L-1:0]    eq_rst_q;
   logic [L*5-1:0]  pre_q;
   logic [L*5-1:0]  post_q;
   logic [L*4-1:0]  swing_q;
   logic [L*2-1:0]  rxpd_q;
   logic [L*2-1:0]  txpd_q;
   logic [31:0]     prdata_q;
   logic            pslverr_q;

   logic            wr_en;
   logic            rd_en;
   logic            hit;
   logic [L-1:0]    pll_s1, pll_s2, rxd_s1, rxd_s2, pmad_s1, pmad_s2;
   logic [L-1:0]    ese_s1, ese_s2, prbs_s1, prbs_s2, comma_s1, comma_s2;

   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign pready = 1'b1;

   always_comb begin
      unique case (paddr)
         tldp_pkg::REG_LOOPBACK, tldp_pkg::REG_TXSWING, tldp_pkg::REG_TXPOL,
         tldp_pkg::REG_RXPOL, tldp_pkg::REG_RXLPMEN, tldp_pkg::REG_RXEQRST,
         tldp_pkg::REG_TXPRE, tldp_pkg::REG_TXPOST, tldp_pkg::REG_RXPD,
         tldp_pkg::REG_TXPD, tldp_pkg::REG_MGMT_EN, tldp_pkg::REG_LANE_STAT: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   // Register writes; the status word is read only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mgmt_en_q  <= 1'b0;
         loopback_q <= '0;
         rx_pol_q   <= '0;
         tx_pol_q   <= '0;
         lpm_q      <= '0;
         eq_rst_q   <= '0;
         pre_q      <= '0;
         post_q     <= '0;
         swing_q    <= '0;
         rxpd_q     <= '0;
         txpd_q     <= '0;
      end else if (wr_en) begin
         unique case (paddr)
            tldp_pkg::REG_MGMT_EN:  mgmt_en_q  <= pwdata[0];
            tldp_pkg::REG_LOOPBACK: loopback_q <= pwdata[L*3-1:0];
            tldp_pkg::REG_RXPOL:    rx_pol_q   <= pwdata[L-1:0];
            tldp_pkg::REG_TXPOL:    tx_pol_q   <= pwdata[L-1:0];
            tldp_pkg::REG_RXLPMEN:  lpm_q      <= pwdata[L-1:0];
            tldp_pkg::REG_RXEQRST:  eq_rst_q   <= pwdata[L-1:0];
            tldp_pkg::REG_TXPRE:    pre_q      <= pwdata[L*5-1:0];
            tldp_pkg::REG_TXPOST:   post_q     <= pwdata[L*5-1:0];
            tldp_pkg::REG_TXSWING:  swing_q    <= pwdata[L*4-1:0];
            tldp_pkg::REG_RXPD:     rxpd_q     <= pwdata[L*2-1:0];
            tldp_pkg::REG_TXPD:     txpd_q     <= pwdata[L*2-1:0];
            default: ;
         endcase
      end
   end

   // Lane status word: one byte per lane
   logic [31:0] stat_word;
   always_comb begin
      stat_word = tldp_pkg::RST_ZERO;
      for (int i = 0; i < L; i++) begin
         stat_word[i*tldp_pkg::ST_STRIDE + tldp_pkg::ST_PLL]   = pll_s2[i];
         stat_word[i*tldp_pkg::ST_STRIDE + tldp_pkg::ST_RXD]   = rxd_s2[i];
         stat_word[i*tldp_pkg::ST_STRIDE + tldp_pkg::ST_PMAD]  = pmad_s2[i];
         stat_word[i*tldp_pkg::ST_STRIDE + tldp_pkg::ST_ESE]   = ese_s2[i];
         stat_word[i*tldp_pkg::ST_STRIDE + tldp_pkg::ST_PRBS]  = prbs_s2[i];
         stat_word[i*tldp_pkg::ST_STRIDE + tldp_pkg::ST_COMMA] = comma_s2[i];
      end
   end

   // Read data and error flag registered at the end of the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= tldp_pkg::RST_ZERO;
         pslverr_q <= 1'b0;
      end else if (psel & ~penable) begin
         pslverr_q <= ~hit;
         prdata_q  <= tldp_pkg::RST_ZERO;
         unique case (paddr)
            tldp_pkg::REG_MGMT_EN:   prdata_q <= {31'h0, mgmt_en_q};
            tldp_pkg::REG_LOOPBACK:  prdata_q[L*3-1:0] <= loopback_q;
            tldp_pkg::REG_RXPOL:     prdata_q[L-1:0]   <= rx_pol_q;
            tldp_pkg::REG_TXPOL:     prdata_q[L-1:0]   <= tx_pol_q;
            tldp_pkg::REG_RXLPMEN:   prdata_q[L-1:0]   <= lpm_q;
            tldp_pkg::REG_RXEQRST:   prdata_q[L-1:0]   <= eq_rst_q;
            tldp_pkg::REG_TXPRE:     prdata_q[L*5-1:0] <= pre_q;
            tldp_pkg::REG_TXPOST:    prdata_q[L*5-1:0] <= post_q;
            tldp_pkg::REG_TXSWING:   prdata_q[L*4-1:0] <= swing_q;
            tldp_pkg::REG_RXPD:      prdata_q[L*2-1:0] <= rxpd_q;
            tldp_pkg::REG_TXPD:      prdata_q[L*2-1:0] <= txpd_q;
            tldp_pkg::REG_LANE_STAT: prdata_q <= stat_word;
            default: ;
         endcase
      end
   end

   assign prdata  = (rd_en) ? prdata_q : tldp_pkg::RST_ZERO;
   assign pslverr = psel & penable & pslverr_q;

   // ------------------------------------------------------------
   // Status synchronisers for the register view
   // ------------------------------------------------------------
   // Asynchronous lane status must not reach the read mux unsynchronised

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {pll_s1, pll_s2, rxd_s1, rxd_s2, pmad_s1, pmad_s2} <= '0;
         {ese_s1, ese_s2, prbs_s1, prbs_s2, comma_s1, comma_s2} <= '0;
      end else begin
         for (int i = 0; i < L; i++) begin
            pll_s1[i]   <= lane_stat[i].pll_locked;
            rxd_s1[i]   <= lane_stat[i].rx_done;
            pmad_s1[i]  <= lane_stat[i].pma_done;
            ese_s1[i]   <= lane_stat[i].eye_err;
            prbs_s1[i]  <= lane_stat[i].prbs_err;
            comma_s1[i] <= lane_stat[i].comma;
         end
         pll_s2   <= pll_s1;
         rxd_s2   <= rxd_s1;
         pmad_s2  <= pmad_s1;
         ese_s2   <= ese_s1;
         prbs_s2  <= prbs_s1;
         comma_s2 <= comma_s1;
      end
   end

   // ------------------------------------------------------------
   // Control path toward the lane_count
   // ------------------------------------------------------------
   // Ports and registers are a pure mux: the lane clocks own timing
   always_comb begin
      for (int i = 0; i < L; i++) begin
         if (mgmt_en_q) begin
            lane_ctrl[i].loopback   = loopback_q[i*3 +: 3];
            lane_ctrl[i].rx_invert  = rx_pol_q[i];
            lane_ctrl[i].tx_invert  = tx_pol_q[i];
            lane_ctrl[i].eq_reset   = eq_rst_q[i];
            lane_ctrl[i].lpm_select = lpm_q[i];
            lane_ctrl[i].pre        = pre_q[i*5 +: 5];
            lane_ctrl[i].post       = post_q[i*5 +: 5];
            lane_ctrl[i].swing      = swing_q[i*4 +: 4];
            lane_ctrl[i].rx_pd      = rxpd_q[i*2 +: 2];
            lane_ctrl[i].tx_pd      = txpd_q[i*2 +: 2];
         end else begin
            lane_ctrl[i].loopback   = lane_loopback_select[i*3 +: 3];
            lane_ctrl[i].rx_invert  = rx_invert_data[i];
            lane_ctrl[i].tx_invert  = tx_invert_data[i];
            lane_ctrl[i].eq_reset   = rx_equaliser_reset[i];
            lane_ctrl[i].lpm_select = rx_low_power_equaliser_select[i];
            lane_ctrl[i].pre        = tx_pre_emphasis_pre[i*5 +: 5];
            lane_ctrl[i].post       = tx_pre_emphasis_post[i*5 +: 5];
            lane_ctrl[i].swing      = tx_driver_swing[i*4 +: 4];
            lane_ctrl[i].rx_pd      = rx_power_down_select[i*2 +: 2];
            lane_ctrl[i].tx_pd      = tx_power_down_select[i*2 +: 2];
         end
      end
   end

   // Loopback decode; undefined codes select no loopback at all
   always_comb begin
      for (int i = 0; i < L; i++) begin
         lane_near_pcs_loop[i] = (lane_ctrl[i].loopback == tldp_pkg::LB_NEAR_PCS);
         lane_near_pma_loop[i] = (lane_ctrl[i].loopback == tldp_pkg::LB_NEAR_PMA);
         lane_far_pma_loop[i]  = (lane_ctrl[i].loopback == tldp_pkg::LB_FAR_PMA);
         lane_far_pcs_loop[i]  = (lane_ctrl[i].loopback == tldp_pkg::LB_FAR_PCS);
      end
   end

   assign lane_pcs_reset        = rx_coding_sublayer_reset;
   assign lane_buf_reset        = rx_elastic_buffer_reset;
   assign lane_rate             = rx_line_rate_select;
   assign lane_eye_trigger      = eye_scan_trigger;
   assign lane_eye_reset        = eye_scan_reset;
   assign lane_force_error      = tx_pattern_force_error;
   assign lane_tx_inhibit       = tx_output_inhibit;
   assign lane_prbs_select      = rx_pattern_checker_select;
   assign lane_prbs_count_clear = rx_pattern_error_count_clear;
   assign lane_cdr_hold         = rx_recovery_loop_hold;

   // ------------------------------------------------------------
   // Status path toward user logic
   // ------------------------------------------------------------
   // Lane clock domains own these; passed through without retiming
   always_comb begin
      for (int i = 0; i < L; i++) begin
         rx_analog_reset_done[i] = lane_stat[i].pma_done;
         rx_reset_complete[i]    = lane_stat[i].rx_done;
         channel_pll_locked[i]   = lane_stat[i].pll_locked;
         eye_scan_error[i]       = lane_stat[i].eye_err;
         rx_pattern_error[i]     = lane_stat[i].prbs_err;
         rx_comma_seen[i]        = lane_stat[i].comma;
      end
   end

   assign tx_elastic_buffer_state = lane_tx_buf_state;
   assign rx_elastic_buffer_state = lane_rx_buf_state;
   assign rx_disparity_error      = lane_disp_err;
   assign rx_invalid_code_error   = lane_code_err;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   mgmt_mux_a: assert property (@(posedge pclk) disable iff (!presetn)
      mgmt_en_q |-> lane_ctrl[0].loopback == loopback_q[2:0])
      else $error("loopback not taken from register in management mode");

   mgmt_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == tldp_pkg::REG_RXPOL) |=> rx_pol_q == $past(pwdata[L-1:0]))
      else $error("receive invert register write lost");

   far_pcs_a: assert property (@(posedge pclk) disable iff (!presetn)
      lane_far_pcs_loop[0] |-> !lane_near_pcs_loop[0] && !lane_far_pma_loop[0]
         && lane_ctrl[0].loopback == tldp_pkg::LB_FAR_PCS)
      else $error("far-end loopback decode wrong");

   near_pma_a: assert property (@(posedge pclk) disable iff (!presetn)
      (lane_ctrl[0].loopback == tldp_pkg::LB_NEAR_PMA) |-> lane_near_pma_loop[0]
         && !lane_near_pcs_loop[0])
      else $error("near-end loopback decode wrong");

   rx_pol_a: assert property (@(posedge pclk) disable iff (!presetn)
      !mgmt_en_q |-> lane_ctrl[0].rx_invert == rx_invert_data[0])
      else $error("receive invert not passed to lane");

   lpm_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
      !mgmt_en_q |-> lane_ctrl[0].lpm_select == rx_low_power_equaliser_select[0])
      else $error("equaliser select not passed to lane");

   stat_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
      (lane_stat[0].pll_locked [*3]) |-> pll_s2[0])
      else $error("lock status not seen after two stages");

   slverr_a: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !hit) ##1 (psel && penable) |-> pslverr)
      else $error("unmapped access not flagged");

   mgmt_en_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == tldp_pkg::REG_MGMT_EN) |=> mgmt_en_q == $past(pwdata[0]))
      else $error("management enable write lost");

   user_loop_a: assert property (@(posedge pclk) disable iff (!presetn)
      !mgmt_en_q |-> lane_ctrl[1].loopback == lane_loopback_select[5:3])
      else $error("loopback port not passed to lane");

   no_loop_a: assert property (@(posedge pclk) disable iff (!presetn)
      (lane_ctrl[1].loopback == tldp_pkg::LB_NONE) |-> !lane_near_pcs_loop[1]
         && !lane_near_pma_loop[1] && !lane_far_pma_loop[1] && !lane_far_pcs_loop[1])
      else $error("loopback decoded for code zero");

   far_pma_a: assert property (@(posedge pclk) disable iff (!presetn)
      (lane_ctrl[1].loopback == tldp_pkg::LB_FAR_PMA) |-> lane_far_pma_loop[1]
         && !lane_far_pcs_loop[1])
      else $error("far-end analog loopback decode wrong");

   rd_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
      !rd_en |-> prdata == tldp_pkg::RST_ZERO)
      else $error("read data outside a read access");

   stat_view_a: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && paddr == tldp_pkg::REG_LANE_STAT)
         |=> prdata_q[tldp_pkg::ST_PMAD] == $past(pmad_s2[0]))
      else $error("analog reset-done missing from status word");

endmodule

/* tldp_lane_model.sv */
// Lane-side model: the hard transceiver lane_count returning status to the block
`timescale 1ns/1ps

module tldp_lane_model (
   input  wire logic [11:0]                                drive_stat,
   output tldp_pkg::tldp_stat_s [tldp_pkg::LANE_COUNT-1:0] lane_stat,
   output logic [3:0]                                      lane_tx_buf_state,
   output logic [5:0]                                      lane_rx_buf_state,
   output logic [7:0]                                      lane_disp_err,
   output logic [7:0]                                      lane_code_err
);
   // -----------------------------------------
   // Status lines, all driven from one knob
   // -----------------------------------------
   // Code errors use the inverse of bits 11:4; the buses match only if bits 3:0 equal bits 11:8 and the inverse of bits 7:4
   assign lane_stat = drive_stat;
   assign lane_tx_buf_state = drive_stat[3:0];
   assign lane_rx_buf_state = drive_stat[11:6];
   assign lane_disp_err = drive_stat[7:0];
   assign lane_code_err = ~drive_stat[11:4];
endmodule

/* tldp_lane_debug_test.sv */
// Testbench: APB register access, passthrough and lane status of the debug port block
`timescale 1ns/1ps

module tldp_lane_debug_test;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr, d;
   logic [31:0] pwdata, prdata, r, x;
   logic [1:0]  pcs, bufr, etrg, erst, rxi, txi, eqr, lpm, ferr, inh, cclr, hold;
   logic [1:0]  adone, rdone, plock, eerr, perr, comma;
   logic [5:0]  rate, loop, rxbuf;
   logic [9:0]  pre, post;
   logic [7:0]  swing, psel_pat, disp, code;
   logic [3:0]  rxpd, txpd, txbuf;
   logic [1:0]  l_pcs, l_buf, l_etrg, l_erst, l_ferr, l_inh, l_cclr, l_hold;
   logic [1:0]  npcs, npma, fpma, fpcs;
   logic [5:0]  l_rate;
   logic [7:0]  l_psel, l_disp, l_code;
   logic [3:0]  l_txbuf;
   logic [5:0]  l_rxbuf;
   logic        e;
   tldp_pkg::tldp_ctrl_s [1:0] ctrl;
   tldp_pkg::tldp_stat_s [1:0] stat;
   int bad_count, total_checks, cyc;
   logic [11:0] offs [11] = '{12'h41c, 12'h508, 12'h510, 12'h604, 12'h608, 12'h60c,
                              12'h418, 12'h414, 12'h404, 12'h504, 12'h700};
   logic [31:0] mask [11] = '{32'h3f, 32'hff, 32'h3, 32'h3, 32'h3, 32'h3,
                              32'h3ff, 32'h3ff, 32'hf, 32'hf, 32'h1};

   tldp_lane_debug i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_coding_sublayer_reset(pcs), .rx_elastic_buffer_reset(bufr),
      .rx_line_rate_select(rate), .eye_scan_trigger(etrg), .eye_scan_reset(erst),
      .lane_loopback_select(loop), .rx_invert_data(rxi), .tx_invert_data(txi),
      .rx_equaliser_reset(eqr), .rx_low_power_equaliser_select(lpm),
      .tx_pre_emphasis_pre(pre), .tx_pre_emphasis_post(post), .tx_driver_swing(swing),
      .rx_power_down_select(rxpd), .tx_power_down_select(txpd),
      .tx_pattern_force_error(ferr), .tx_output_inhibit(inh),
      .rx_pattern_checker_select(psel_pat), .rx_pattern_error_count_clear(cclr),
      .rx_recovery_loop_hold(hold), .rx_analog_reset_done(adone),
      .rx_reset_complete(rdone), .tx_elastic_buffer_state(txbuf),
      .rx_elastic_buffer_state(rxbuf), .channel_pll_locked(plock), .eye_scan_error(eerr),
      .rx_pattern_error(perr), .rx_disparity_error(disp), .rx_invalid_code_error(code),
      .rx_comma_seen(comma), .lane_ctrl(ctrl), .lane_pcs_reset(l_pcs),
      .lane_buf_reset(l_buf), .lane_rate(l_rate), .lane_eye_trigger(l_etrg),
      .lane_eye_reset(l_erst), .lane_force_error(l_ferr), .lane_tx_inhibit(l_inh),
      .lane_prbs_select(l_psel), .lane_prbs_count_clear(l_cclr), .lane_cdr_hold(l_hold),
      .lane_near_pcs_loop(npcs), .lane_near_pma_loop(npma), .lane_far_pma_loop(fpma),
      .lane_far_pcs_loop(fpcs), .lane_stat(stat), .lane_tx_buf_state(l_txbuf),
      .lane_rx_buf_state(l_rxbuf), .lane_disp_err(l_disp), .lane_code_err(l_code));

   tldp_lane_model i_lane_count (.drive_stat(d), .lane_stat(stat), .lane_tx_buf_state(l_txbuf),
      .lane_rx_buf_state(l_rxbuf), .lane_disp_err(l_disp), .lane_code_err(l_code));

   // -----------------------------------------
   // Clock, reset and timeout
   // -----------------------------------------
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         bad_count = bad_count + 1;
         print_verdict();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Waits on pready rather than assuming zero wait states
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic set_user(input logic [7:0] p, input logic [5:0] lb);
      @(posedge pclk);
      {pcs, bufr, etrg, erst} <= p;
      {rxi, txi, eqr, lpm} <= ~p;
      {ferr, inh, cclr, hold} <= {p[3:0], p[7:4]};
      {rate, loop} <= {p[5:0], lb};
      {pre, post} <= {p, p, ~p[3:0]};
      {swing, psel_pat} <= {~p, p};
      {rxpd, txpd} <= p;
      @(negedge pclk);
   endtask

   // -----------------------------------------
   // Main sequence
   // -----------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata, d, bad_count, total_checks} = '0;
      presetn = 1'b0;
      set_user(8'h00, 6'h00);
      repeat (11) @(posedge pclk);
      presetn <= 1'b1;
      foreach (offs[i]) begin
         apb(1'b0, offs[i], 32'h0);
         chk(r, 32'h0);
         apb(1'b1, offs[i], 32'hffffffff);
         apb(1'b0, offs[i], 32'h0);
         chk(r, mask[i]);
         chk({31'h0, e}, 32'h0);
         apb(1'b1, offs[i], 32'h0);
      end
      apb(1'b0, 12'h7fc, 32'h0);
      chk(r, 32'h0);
      chk({31'h0, e}, 32'h1);
      foreach (offs[i]) begin
         set_user(8'ha5 ^ 8'(i * 37), 6'h00);
         chk({l_pcs, l_buf, l_etrg, l_erst, l_ferr, l_inh, l_cclr, l_hold},
             {pcs, bufr, etrg, erst, ferr, inh, cclr, hold});
         chk({l_rate, l_psel}, {rate, psel_pat});
         for (int k = 0; k < 2; k++)
            chk(ctrl[k], {loop[k*3+:3], rxi[k], txi[k], eqr[k], lpm[k], pre[k*5+:5],
                post[k*5+:5], swing[k*4+:4], rxpd[k*2+:2], txpd[k*2+:2]});
      end
      // Undefined codes 3, 5 and 7 must light no decode line
      for (int c = 0; c < 8; c++) begin
         set_user(8'h00, {3'(c), 3'(7 - c)});
         for (int k = 0; k < 2; k++) begin
            x[2:0] = 3'(k ? c : 7 - c);
            chk({npcs[k], npma[k], fpma[k], fpcs[k]}, {x[2:0] == 3'h1, x[2:0] == 3'h2,
                x[2:0] == 3'h4, x[2:0] == 3'h6});
         end
      end
      apb(1'b1, tldp_pkg::REG_LOOPBACK, 32'h34);
      apb(1'b1, tldp_pkg::REG_RXPOL, 32'h2);
      apb(1'b1, tldp_pkg::REG_MGMT_EN, 32'h1);
      @(negedge pclk);
      chk({fpcs, fpma, ctrl[1].rx_invert, ctrl[0].rx_invert}, 6'b100110);
      @(posedge pclk);
      foreach (mask[i]) begin
         d <= 12'hc35 ^ 12'(i * 291);
         apb(1'b1, tldp_pkg::REG_LANE_STAT, 32'hffffffff);
         chk({adone, rdone, plock}, {d[9], d[3], d[10], d[4], d[11], d[5]});
         chk({eerr, perr, comma}, {d[8], d[2], d[7], d[1], d[6], d[0]});
         chk({txbuf, rxbuf}, {d[3:0], d[11:6]});
         chk({disp, code}, {d[7:0], ~d[11:4]});
         apb(1'b0, tldp_pkg::REG_LANE_STAT, 32'h0);
         for (int b = 0; b < 12; b++) x[b + 2 * (b / 6)] = d[(b / 6) * 6 + 5 - b % 6];
         chk(r, {16'h0, 2'b0, x[13:8], 2'b0, x[5:0]});
      end
      print_verdict();
   end
endmodule
